// *** rtl/cpm_top.sv ***
// Counter channel: pulse width, position, compare and one-shot with APB and DMA stream
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module cpm_top (
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire cpm_pkg::cpm_pins_s PINS_IN,
	output logic CNT_OUT_OUT,
	output logic MATCH_IRQ_OUT,
	output logic DMA_VALID_OUT,
	output cpm_pkg::cpm_beat_s DMA_BEAT_OUT,
	input wire logic DMA_READY_IN
);
	import cpm_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] s1_reg;
	logic [4:0] s2_reg;
	logic [4:0] s3_reg;
	logic [4:0] flt_reg;
	logic [4:0] flt_d_reg;
	logic [4:0] pin_raw;
	cpm_pins_s lvl;
	cpm_pins_s rise;
	cpm_pins_s fall;

	assign pin_raw = PINS_IN;
	assign lvl = flt_reg;
	assign rise = flt_reg & ~flt_d_reg;
	assign fall = ~flt_reg & flt_d_reg;

	// A change is accepted only once two stages agree, which rejects one-cycle glitches
	for (genvar g = 0; g < 5; g++) begin : g_sync
		always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
			if (!RST_B_IN) begin
				s1_reg[g] <= 1'b0;
				s2_reg[g] <= 1'b0;
				s3_reg[g] <= 1'b0;
				flt_reg[g] <= 1'b0;
				flt_d_reg[g] <= 1'b0;
			end else begin
				s1_reg[g] <= pin_raw[g];
				s2_reg[g] <= s1_reg[g];
				s3_reg[g] <= s2_reg[g];
				if (s2_reg[g] == s3_reg[g]) begin
					flt_reg[g] <= s3_reg[g];
				end
				flt_d_reg[g] <= flt_reg[g];
			end
		end
	end

	// ****************************************
	// Functions
	// ****************************************
	// Returns {down, up} for edges of one quadrature line against the other line's level
	function automatic logic [1:0] quad_dir(input logic r, input logic f, input logic o);
		quad_dir = {(r & o) | (f & ~o), (r & ~o) | (f & o)};
	endfunction : quad_dir

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction : sat_inc

	// ****************************************
	// Registers and APB decode
	// ****************************************
	cpm_ctrl_s ctrl_reg;
	logic [31:0] rst_val_reg;
	logic [31:0] offset_reg;
	logic [31:0] width_reg;
	logic [31:0] delay_reg;
	logic [31:0] sdiv_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rd_mux;
	logic setup;
	logic wr;
	logic addr_ok;
	logic cmd_wr;
	logic cmp_wr;

	assign setup = PSEL_IN & ~PENABLE_IN;
	assign wr = PSEL_IN & PENABLE_IN & pready_reg & PWRITE_IN;
	assign addr_ok = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN <= OFF_STATUS);
	assign cmd_wr = wr & (PADDR_IN == OFF_CMD);
	assign cmp_wr = wr & (PADDR_IN == OFF_CMP);

	// No wait state: the answer is prepared during setup and pready stands in the first access cycle
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup & ~addr_ok;
			if (setup) begin
				prdata_reg <= (addr_ok & ~PWRITE_IN) ? rd_mux : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl_reg <= '0;
			rst_val_reg <= 32'h0000_0000;
			offset_reg <= 32'h0000_0000;
			width_reg <= WIDTH_RST;
			delay_reg <= DELAY_RST;
			sdiv_reg <= SDIV_RST;
		end else if (wr) begin
			unique case (PADDR_IN)
				OFF_CTRL: ctrl_reg <= PWDATA_IN;
				OFF_RST_VAL: rst_val_reg <= PWDATA_IN;
				OFF_OFFSET: offset_reg <= PWDATA_IN;
				OFF_WIDTH: width_reg <= PWDATA_IN;
				OFF_DELAY: delay_reg <= PWDATA_IN;
				OFF_SDIV: sdiv_reg <= PWDATA_IN;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Sample clock
	// ****************************************
	logic [31:0] sdiv_cnt_reg;
	logic int_tick;
	logic sclk_tick;

	assign int_tick = ctrl_reg.en & (sdiv_cnt_reg + 32'h0000_0001 >= sdiv_reg);
	assign sclk_tick = ctrl_reg.sclk_ext ? (ctrl_reg.en & rise.sclk) : int_tick;

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			sdiv_cnt_reg <= 32'h0000_0000;
		end else begin
			sdiv_cnt_reg <= (int_tick | ~ctrl_reg.en) ? 32'h0000_0000 : sdiv_cnt_reg + 32'h0000_0001;
		end
	end

	// ****************************************
	// Pulse width measurement
	// ****************************************
	logic pw_act;
	logic [15:0] hi_run_reg;
	logic [15:0] lo_run_reg;
	logic [15:0] hi_hold_reg;
	logic [15:0] high_reg;
	logic [15:0] low_reg;
	logic seen_fall_reg;
	logic pw_done_reg;

	assign pw_act = ctrl_reg.en & (ctrl_reg.mode == MODE_PW);

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			hi_run_reg <= 16'h0000;
			lo_run_reg <= 16'h0000;
			hi_hold_reg <= 16'h0000;
			high_reg <= 16'h0000;
			low_reg <= 16'h0000;
			seen_fall_reg <= 1'b0;
			pw_done_reg <= 1'b0;
		end else if (!pw_act) begin
			hi_run_reg <= 16'h0000;
			lo_run_reg <= 16'h0000;
			seen_fall_reg <= 1'b0;
			pw_done_reg <= 1'b0;
		end else begin
			pw_done_reg <= rise.a & seen_fall_reg;
			if (lvl.a) begin
				hi_run_reg <= rise.a ? 16'h0001 : sat_inc(hi_run_reg);
			end else begin
				lo_run_reg <= fall.a ? 16'h0001 : sat_inc(lo_run_reg);
			end
			if (fall.a) begin
				hi_hold_reg <= hi_run_reg;
				seen_fall_reg <= 1'b1;
			end
			// A pulse is complete at the rise that ends its low part
			if (rise.a & seen_fall_reg) begin
				high_reg <= hi_hold_reg;
				low_reg <= lo_run_reg;
			end
		end
	end

	// ****************************************
	// Position counter
	// ****************************************
	logic pos_act;
	logic [31:0] pos_reg;
	logic [1:0] qa;
	logic [1:0] qb;
	logic step_up;
	logic step_dn;
	logic pos_load;

	assign pos_act = ctrl_reg.en & (ctrl_reg.mode == MODE_POS);
	assign qa = quad_dir(rise.a, fall.a, lvl.b);
	assign qb = quad_dir(rise.b, fall.b, lvl.a);
	assign step_up = (ctrl_reg.enc == ENC_X2) ? qa[0] :
		(ctrl_reg.enc == ENC_X4) ? (qa[0] | qb[1]) :
		(ctrl_reg.enc == ENC_TWO) ? rise.a :
		(rise.a & ~lvl.b);
	assign step_dn = (ctrl_reg.enc == ENC_X2) ? qa[1] :
		(ctrl_reg.enc == ENC_X4) ? (qa[1] | qb[0]) :
		(ctrl_reg.enc == ENC_TWO) ? rise.b :
		(rise.a & lvl.b);
	assign pos_load = pos_act & ((cmd_wr & PWDATA_IN[CMD_POS_LOAD]) | (ctrl_reg.z_en & lvl.z));

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pos_reg <= 32'h0000_0000;
		end else if (pos_load) begin
			pos_reg <= rst_val_reg;
		end else if (pos_act & step_up & ~step_dn) begin
			pos_reg <= pos_reg + 32'h0000_0001;
		end else if (pos_act & step_dn & ~step_up) begin
			pos_reg <= pos_reg - 32'h0000_0001;
		end
	end

	// ****************************************
	// Data FIFO and DMA block stream
	// ****************************************
	logic [31:0] dmem [DATA_DEPTH];
	logic [DATA_AW-1:0] dwr_reg;
	logic [DATA_AW-1:0] drd_reg;
	logic [6:0] dlvl_reg;
	logic ovf_reg;
	logic fifo_clr;
	logic dpush;
	logic dpush_ok;
	logic [31:0] dpush_data;
	logic [4:0] rem_reg;
	logic dma_start;
	logic dma_take;
	logic dma_vld_reg;
	cpm_beat_s beat_reg;

	assign fifo_clr = cmd_wr & PWDATA_IN[CMD_FIFO_CLR];
	assign dpush = ctrl_reg.en & (ctrl_reg.mode != MODE_ONESHOT) &
		(((ctrl_reg.buf_mode == BUF_SCLK) & sclk_tick) |
		((ctrl_reg.buf_mode == BUF_IMPLICIT) & pw_done_reg));
	assign dpush_data = (ctrl_reg.mode == MODE_POS) ? pos_reg : {high_reg, low_reg};
	assign dpush_ok = dpush & (dlvl_reg != 7'(DATA_DEPTH));
	// A burst starts only when a whole block is waiting, so it never runs dry midway
	assign dma_start = (rem_reg == 5'h00) & (dlvl_reg >= 7'(BLOCK_LEN));
	assign dma_take = (rem_reg != 5'h00) & (dlvl_reg != 7'h00) & (~dma_vld_reg | DMA_READY_IN);

	always_ff @(posedge CLK_IN) begin
		if (dpush_ok) begin
			dmem[dwr_reg] <= dpush_data;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			dwr_reg <= '0;
			drd_reg <= '0;
			dlvl_reg <= 7'h00;
			ovf_reg <= 1'b0;
			rem_reg <= 5'h00;
		end else if (fifo_clr) begin
			dwr_reg <= '0;
			drd_reg <= '0;
			dlvl_reg <= 7'h00;
			ovf_reg <= dpush & ~dpush_ok;
			rem_reg <= 5'h00;
		end else begin
			if (dpush_ok) begin
				dwr_reg <= dwr_reg + 1'b1;
			end
			if (dma_take) begin
				drd_reg <= drd_reg + 1'b1;
			end
			dlvl_reg <= dlvl_reg + 7'(dpush_ok) - 7'(dma_take);
			if (dpush & ~dpush_ok) begin
				ovf_reg <= 1'b1;
			end
			if (dma_start) begin
				rem_reg <= 5'(BLOCK_LEN);
			end else if (dma_take) begin
				rem_reg <= rem_reg - 5'h01;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			dma_vld_reg <= 1'b0;
			beat_reg <= '0;
		end else if (dma_take) begin
			dma_vld_reg <= 1'b1;
			beat_reg <= {rem_reg == 5'h01, dmem[drd_reg]};
		end else if (DMA_READY_IN) begin
			dma_vld_reg <= 1'b0;
		end
	end

	// ****************************************
	// Position compare
	// ****************************************
	logic [31:0] cmem [CMP_DEPTH];
	logic [CMP_AW-1:0] cwr_reg;
	logic [CMP_AW-1:0] crd_reg;
	logic [4:0] clvl_reg;
	logic [31:0] cmp_cur_reg;
	logic cmp_have_reg;
	logic eq_d_reg;
	logic eq;
	logic match;
	logic cfifo_mode;
	logic cpush;
	logic cload;
	logic [31:0] cmp_cnt_reg;
	logic irq_reg;
	cpm_ctrl_s ctrl_wdata;
	logic cmode_chg;

	assign ctrl_wdata = PWDATA_IN;
	// A value left from another compare mode must never act as the first compare value
	assign cmode_chg = wr & (PADDR_IN == OFF_CTRL) &
		(ctrl_wdata.cmp_mode != ctrl_reg.cmp_mode);
	assign cfifo_mode = ctrl_reg.cmp_mode == CMP_FIFO;
	assign eq = pos_act & cmp_have_reg & (ctrl_reg.cmp_mode != CMP_OFF) & (pos_reg == cmp_cur_reg);
	assign match = eq & ~eq_d_reg;
	assign cpush = cmp_wr & cfifo_mode & (clvl_reg != 5'(CMP_DEPTH));
	assign cload = cfifo_mode & (clvl_reg != 5'h00) & (~cmp_have_reg | match) &
		~cmode_chg;

	always_ff @(posedge CLK_IN) begin
		if (cpush) begin
			cmem[cwr_reg] <= PWDATA_IN;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			cwr_reg <= '0;
			crd_reg <= '0;
			clvl_reg <= 5'h00;
			cmp_cur_reg <= 32'h0000_0000;
			cmp_have_reg <= 1'b0;
			eq_d_reg <= 1'b0;
		end else begin
			eq_d_reg <= eq;
			if (cpush) begin
				cwr_reg <= cwr_reg + 1'b1;
			end
			if (cload) begin
				crd_reg <= crd_reg + 1'b1;
			end
			clvl_reg <= clvl_reg + 5'(cpush) - 5'(cload);
			if (cmode_chg) begin
				cmp_have_reg <= 1'b0;
			end else if (cmp_wr & (ctrl_reg.cmp_mode == CMP_INSTANT)) begin
				cmp_cur_reg <= PWDATA_IN;
				cmp_have_reg <= 1'b1;
			end else if ((ctrl_reg.cmp_mode == CMP_OFFSET) & sclk_tick) begin
				cmp_cur_reg <= pos_reg + offset_reg;
				cmp_have_reg <= 1'b1;
			end else if (cload) begin
				cmp_cur_reg <= cmem[crd_reg];
				cmp_have_reg <= 1'b1;
			end else if ((cfifo_mode & match) | (ctrl_reg.cmp_mode == CMP_OFF)) begin
				cmp_have_reg <= 1'b0;
			end
		end
	end

	// Zero width is treated as one cycle so a match is never silent
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			cmp_cnt_reg <= 32'h0000_0000;
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= match & (ctrl_reg.cmp_mode == CMP_INSTANT);
			if (match) begin
				cmp_cnt_reg <= (width_reg == 32'h0000_0000) ? WIDTH_RST : width_reg;
			end else if (cmp_cnt_reg != 32'h0000_0000) begin
				cmp_cnt_reg <= cmp_cnt_reg - 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// One-shot
	// ****************************************
	cpm_os_e os_state_reg;
	cpm_os_e os_state_next;
	logic [31:0] os_cnt_reg;
	logic os_act;
	logic os_reached;

	assign os_act = ctrl_reg.en & (ctrl_reg.mode == MODE_ONESHOT);
	assign os_reached = os_cnt_reg + 32'h0000_0001 >= delay_reg;

	always_comb begin
		os_state_next = os_state_reg;
		unique case (os_state_reg)
			OS_IDLE: if (gate_ok()) os_state_next = OS_WAIT;
			OS_WAIT: if (rise.a & os_reached) os_state_next = OS_PULSE;
			OS_PULSE: if (rise.a) os_state_next = OS_IDLE;
		endcase
		if (!os_act) begin
			os_state_next = OS_IDLE;
		end
	end

	function automatic logic gate_ok();
		gate_ok = rise.gate;
	endfunction : gate_ok

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			os_state_reg <= OS_IDLE;
			os_cnt_reg <= 32'h0000_0000;
		end else begin
			os_state_reg <= os_state_next;
			if (os_state_reg != OS_WAIT) begin
				os_cnt_reg <= 32'h0000_0000;
			end else if (rise.a) begin
				os_cnt_reg <= os_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// Read mux and outputs
	// ****************************************
	cpm_status_s status;
	logic [31:0] live_count;
	logic out_reg;

	assign status = '{rsvd: '0, cmp_full: clvl_reg == 5'(CMP_DEPTH), cmp_have: cmp_have_reg,
		ovf: ovf_reg, cmp_lvl: clvl_reg, dat_lvl: dlvl_reg};
	assign live_count = (ctrl_reg.mode == MODE_POS) ? pos_reg :
		(ctrl_reg.mode == MODE_ONESHOT) ? os_cnt_reg :
		{16'h0000, lvl.a ? hi_run_reg : lo_run_reg};
	assign rd_mux = (PADDR_IN == OFF_CTRL) ? 32'(ctrl_reg) :
		(PADDR_IN == OFF_RST_VAL) ? rst_val_reg :
		(PADDR_IN == OFF_CMP) ? cmp_cur_reg :
		(PADDR_IN == OFF_OFFSET) ? offset_reg :
		(PADDR_IN == OFF_WIDTH) ? width_reg :
		(PADDR_IN == OFF_DELAY) ? delay_reg :
		(PADDR_IN == OFF_SDIV) ? sdiv_reg :
		(PADDR_IN == OFF_COUNT) ? live_count :
		(PADDR_IN == OFF_PWIDTH) ? {high_reg, low_reg} :
		(PADDR_IN == OFF_STATUS) ? 32'(status) : 32'h0000_0000;

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= os_act ? (os_state_reg == OS_PULSE) :
				(pos_act & (cmp_cnt_reg != 32'h0000_0000));
		end
	end

	assign PRDATA_OUT = prdata_reg;
	assign PREADY_OUT = pready_reg;
	assign PSLVERR_OUT = pslverr_reg;
	assign CNT_OUT_OUT = out_reg;
	assign MATCH_IRQ_OUT = irq_reg;
	assign DMA_VALID_OUT = dma_vld_reg;
	assign DMA_BEAT_OUT = beat_reg;

endmodule : cpm_top

// *** rtl/cpm_pkg.sv ***
// Constants, field layouts and carrier types of the counter position/measure/compare channel
package cpm_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_RST_VAL = 8'h08;
	localparam logic [7:0] OFF_CMP = 8'h0C;
	localparam logic [7:0] OFF_OFFSET = 8'h10;
	localparam logic [7:0] OFF_WIDTH = 8'h14;
	localparam logic [7:0] OFF_DELAY = 8'h18;
	localparam logic [7:0] OFF_SDIV = 8'h1C;
	localparam logic [7:0] OFF_COUNT = 8'h20;
	localparam logic [7:0] OFF_PWIDTH = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0] MODE_PW = 2'h0;
	localparam logic [1:0] MODE_POS = 2'h1;
	localparam logic [1:0] MODE_ONESHOT = 2'h2;
	localparam logic [2:0] ENC_X1 = 3'h0;
	localparam logic [2:0] ENC_X2 = 3'h1;
	localparam logic [2:0] ENC_X4 = 3'h2;
	localparam logic [2:0] ENC_TWO = 3'h3;
	localparam logic [2:0] ENC_DIR = 3'h4;
	localparam logic [1:0] BUF_INSTANT = 2'h0;
	localparam logic [1:0] BUF_SCLK = 2'h1;
	localparam logic [1:0] BUF_IMPLICIT = 2'h2;
	localparam logic [1:0] CMP_OFF = 2'h0;
	localparam logic [1:0] CMP_INSTANT = 2'h1;
	localparam logic [1:0] CMP_FIFO = 2'h2;
	localparam logic [1:0] CMP_OFFSET = 2'h3;
	localparam int CMD_POS_LOAD = 0;
	localparam int CMD_FIFO_CLR = 1;

	// ****************************************
	// Sizes, reset values and timing
	// ****************************************
	localparam int DATA_DEPTH = 64;
	localparam int DATA_AW = 6;
	localparam int CMP_DEPTH = 16;
	localparam int CMP_AW = 4;
	localparam int BLOCK_LEN = 16;
	localparam int CLK_MHZ = 200;
	localparam int SCLK_DEF_NS = 1000;
	localparam logic [31:0] SDIV_RST = 32'(SCLK_DEF_NS * CLK_MHZ / 1000);
	localparam logic [31:0] WIDTH_RST = 32'h0000_0001;
	localparam logic [31:0] DELAY_RST = 32'h0000_0001;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic [19:0] rsvd;
		logic z_en;
		logic sclk_ext;
		logic [1:0] cmp_mode;
		logic [1:0] buf_mode;
		logic [2:0] enc;
		logic [1:0] mode;
		logic en;
	} cpm_ctrl_s;

	typedef struct packed {
		logic [16:0] rsvd;
		logic cmp_full;
		logic cmp_have;
		logic ovf;
		logic [4:0] cmp_lvl;
		logic [6:0] dat_lvl;
	} cpm_status_s;

	typedef struct packed {
		logic sclk;
		logic gate;
		logic z;
		logic b;
		logic a;
	} cpm_pins_s;

	typedef struct packed {
		logic last;
		logic [31:0] data;
	} cpm_beat_s;

	typedef enum logic [1:0] {OS_IDLE, OS_WAIT, OS_PULSE} cpm_os_e;

endpackage : cpm_pkg

// *** tb/cpm_sva.sv ***
// Port-level checker of the counter channel
`timescale 1ns/1ps
module cpm_sva
	import cpm_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic CNT_OUT_OUT,
	input wire logic MATCH_IRQ_OUT,
	input wire logic DMA_VALID_OUT,
	input wire cpm_pkg::cpm_beat_s DMA_BEAT_OUT,
	input wire logic DMA_READY_IN
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	// Beats taken in the current block, so the closing flag can be tied to the 16th
	logic [4:0] beat_cnt_reg;
	logic [4:0] beat_cnt_next;
	assign beat_cnt_next = DMA_BEAT_OUT.last ? 5'h00 : beat_cnt_reg + 5'h01;
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			beat_cnt_reg <= 5'h00;
		end else if (DMA_VALID_OUT && DMA_READY_IN) begin
			beat_cnt_reg <= beat_cnt_next;
		end
	end
	a_ready_no_wait: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
		else $error("access phase not answered at once");
	a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	a_err_addr_map: assert property (PSEL_IN && !PENABLE_IN |=>
		PSLVERR_OUT == (PADDR_IN > 8'h28 || PADDR_IN[1:0] != 2'h0))
		else $error("error response disagrees with address");
	a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
	a_irq_single: assert property (MATCH_IRQ_OUT |=> !MATCH_IRQ_OUT)
		else $error("match interrupt longer than one cycle");
	a_irq_drives_out: assert property ($rose(MATCH_IRQ_OUT) |-> ##[0:2] CNT_OUT_OUT)
		else $error("match without output pulse");
	a_dma_hold: assert property (DMA_VALID_OUT && !DMA_READY_IN |=>
		DMA_VALID_OUT && $stable(DMA_BEAT_OUT))
		else $error("stalled beat changed");
	a_dma_block_len: assert property (DMA_VALID_OUT |->
		DMA_BEAT_OUT.last == (beat_cnt_reg == 5'h0F))
		else $error("block closing beat misplaced");
endmodule : cpm_sva
bind cpm_top cpm_sva chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.CNT_OUT_OUT(CNT_OUT_OUT), .MATCH_IRQ_OUT(MATCH_IRQ_OUT), .DMA_VALID_OUT(DMA_VALID_OUT),
	.DMA_BEAT_OUT(DMA_BEAT_OUT), .DMA_READY_IN(DMA_READY_IN));

// *** tb/cpm_far_model.sv ***
// Far-side model driving encoder, index, gate and external sample clock pins
`timescale 1ns/1ps
module cpm_far_model
	import cpm_pkg::*;
(
	input wire logic clk_in,
	output cpm_pkg::cpm_pins_s pins_out
);
	logic pw_run = 1'b0;
	logic [3:0] ph = 4'h0;
	initial pins_out = '0;
	// Free-running source on a: 6 cycles high, 10 low
	always @(posedge clk_in) begin
		if (pw_run) begin
			ph <= ph + 4'h1;
			pins_out.a <= ph < 4'h6;
		end
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
	endtask : hold
	// Each level is held 6 cycles because the pin filter loses pulses under 2
	task automatic quad(input int n, input logic fwd);
		for (int i = 0; i < 4 * n; i++) begin
			hold(6);
			if ((i % 2 == 0) == fwd) pins_out.a <= ~pins_out.a;
			else pins_out.b <= ~pins_out.b;
		end
	endtask : quad
	task automatic lvl(input int idx, input logic v);
		hold(6);
		pins_out[idx] <= v;
	endtask : lvl
	task automatic pls(input int idx, input int n);
		repeat (n) begin
			lvl(idx, 1'b1);
			lvl(idx, 1'b0);
		end
		hold(6);
	endtask : pls
	task automatic gate;
		@(posedge pins_out.a);
		hold(1);
		pins_out.gate <= 1'b1;
		hold(8);
		pins_out.gate <= 1'b0;
	endtask : gate
endmodule : cpm_far_model

// *** tb/tb_top.sv ***
// Self-checking bench of the counter channel
`timescale 1ns/1ps
module tb_top;
	import cpm_pkg::*;
	logic clk;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic dready = 1'b0;
	logic dma_run = 1'b0;
	logic [7:0] lf = 8'h23;
	logic [31:0] prdata;
	logic pready, pslverr, cnt_out, irq, dvalid, a_q, g_q, o_q;
	cpm_pins_s pins;
	cpm_beat_s beat;
	logic [32:0] rd_q[$];
	logic [32:0] dma_q[$];
	logic [31:0] pos_exp [5] = '{32'h2, 32'h4, 32'h8, 32'h2, 32'h2};
	logic [31:0] rv;
	int fails = 0;
	int tests_run = 0;
	int hi_run = 0;
	int hi_len = 0;
	int irq_n = 0;
	int out_n = 0;
	int a_n = 0;
	int a_at_out = 0;
	cpm_top dut (.CLK_IN(clk), .RST_B_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PINS_IN(pins), .CNT_OUT_OUT(cnt_out),
		.MATCH_IRQ_OUT(irq), .DMA_VALID_OUT(dvalid), .DMA_BEAT_OUT(beat), .DMA_READY_IN(dready));
	cpm_far_model far (.clk_in(clk), .pins_out(pins));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next
	function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] e,
		input logic [1:0] bm, input logic [1:0] cm, input logic se, input logic ze);
		return {20'h0, ze, se, cm, bm, e, m, 1'b1};
	endfunction : ctl
	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic end_sim;
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic settle;
		repeat (12) @(posedge clk);
	endtask : settle
	task automatic push_blk(input logic [31:0] d);
		for (int i = 0; i < 16; i++) dma_q.push_back({i == 15, d});
	endtask : push_blk
	// Bounded wait so a missing block shows as leftover notes, not a hang
	task automatic drain;
		for (int n = 0; n < 3000 && dma_q.size() > 0; n++) @(posedge clk);
		chk("beats left", 33'h0, 33'(dma_q.size()));
	endtask : drain
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("read", rd_q.size() > 0 ? rd_q.pop_front() : 33'bx, {pslverr, prdata});
		if (dvalid === 1'b1 && dready)
			chk("beat", dma_q.size() > 0 ? dma_q.pop_front() : 33'bx, beat);
		if (irq === 1'b1) irq_n++;
		if (cnt_out === 1'b1) hi_run++;
		else if (hi_run > 0) begin
			hi_len = hi_run;
			hi_run = 0;
		end
		if (pins.a && !a_q) a_n++;
		if (pins.gate && !g_q) a_n = 0;
		if (cnt_out && !o_q) begin
			out_n++;
			a_at_out = a_n;
		end
		a_q = pins.a;
		g_q = pins.gate;
		o_q = cnt_out;
		lf <= lfsr_next(lf);
		dready <= dma_run & lf[0];
	end
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		rd(OFF_WIDTH, {1'b0, WIDTH_RST});
		rd(OFF_DELAY, {1'b0, DELAY_RST});
		rd(OFF_SDIV, {1'b0, SDIV_RST});
		rd(8'h2C, {1'b1, 32'h0});
		$display("done reset values");
		for (int i = 0; i < 5; i++) begin
			wr(OFF_CTRL, ctl(MODE_POS, 3'(i), BUF_INSTANT, CMP_OFF, 1'b0, 1'b0));
			wr(OFF_CMD, 32'h1);
			if (i < 3) begin
				far.quad(3, 1'b1);
				far.quad(1, 1'b0);
			end else if (i == 3) begin
				far.pls(1, 1);
				rd(OFF_COUNT, {1'b0, 32'hFFFF_FFFF});
				far.pls(0, 3);
			end else begin
				far.pls(0, 3);
				far.lvl(1, 1'b1);
				far.pls(0, 1);
				far.lvl(1, 1'b0);
			end
			settle();
			rd(OFF_COUNT, {1'b0, pos_exp[i]});
		end
		$display("done position modes");
		rv = {4{lf}};
		wr(OFF_RST_VAL, rv);
		wr(OFF_CTRL, ctl(MODE_POS, ENC_TWO, BUF_INSTANT, CMP_OFF, 1'b0, 1'b1));
		far.pls(2, 1);
		rd(OFF_COUNT, {1'b0, rv});
		far.pls(0, 2);
		wr(OFF_CMD, 32'h1);
		rd(OFF_COUNT, {1'b0, rv});
		wr(OFF_RST_VAL, 32'h0);
		wr(OFF_CTRL, ctl(MODE_POS, ENC_TWO, BUF_INSTANT, CMP_INSTANT, 1'b0, 1'b0));
		wr(OFF_CMD, 32'h1);
		wr(OFF_WIDTH, 32'h3);
		wr(OFF_CMP, 32'h2);
		irq_n = 0;
		far.pls(0, 3);
		settle();
		chk("irq count", 33'h1, 33'(irq_n));
		chk("out width", 33'h3, 33'(hi_len));
		wr(OFF_CTRL, ctl(MODE_POS, ENC_TWO, BUF_INSTANT, CMP_FIFO, 1'b0, 1'b0));
		wr(OFF_CMD, 32'h1);
		wr(OFF_CMP, 32'h1);
		wr(OFF_CMP, 32'h3);
		out_n = 0;
		far.pls(0, 4);
		far.pls(1, 3);
		far.pls(0, 2);
		settle();
		chk("fifo matches", 33'h2, 33'(out_n));
		wr(OFF_CTRL, ctl(MODE_POS, ENC_TWO, BUF_SCLK, CMP_OFFSET, 1'b1, 1'b0));
		wr(OFF_OFFSET, 32'h2);
		wr(OFF_CMD, 32'h1);
		far.pls(4, 1);
		rd(OFF_CMP, {1'b0, 32'h2});
		out_n = 0;
		far.pls(0, 2);
		settle();
		chk("offset matches", 33'h1, 33'(out_n));
		$display("done compare");
		wr(OFF_CTRL, ctl(MODE_POS, ENC_TWO, BUF_SCLK, CMP_OFF, 1'b1, 1'b0));
		wr(OFF_CMD, 32'h2);
		push_blk(32'h2);
		dma_run = 1'b1;
		far.pls(4, 16);
		drain();
		wr(OFF_SDIV, 32'h8);
		push_blk(32'h2);
		wr(OFF_CTRL, ctl(MODE_POS, ENC_TWO, BUF_SCLK, CMP_OFF, 1'b0, 1'b0));
		drain();
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CMD, 32'h2);
		$display("done sampled stream");
		wr(OFF_CTRL, ctl(MODE_PW, ENC_X1, BUF_IMPLICIT, CMP_OFF, 1'b0, 1'b0));
		far.pw_run = 1'b1;
		repeat (40) @(posedge clk);
		wr(OFF_CMD, 32'h2);
		push_blk(32'h0006_000A);
		drain();
		@(posedge far.pins_out.a);
		far.pw_run = 1'b0;
		repeat (30) @(posedge clk);
		rd(OFF_PWIDTH, {1'b0, 32'h0006_000A});
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CMD, 32'h2);
		$display("done pulse width");
		wr(OFF_DELAY, 32'h3);
		wr(OFF_CTRL, ctl(MODE_ONESHOT, ENC_X1, BUF_INSTANT, CMP_OFF, 1'b0, 1'b0));
		far.pw_run = 1'b1;
		far.gate();
		repeat (120) @(posedge clk);
		chk("shot delay", 33'h3, 33'(a_at_out));
		chk("shot width", 33'h10, 33'(hi_len));
		$display("done one-shot");
		end_sim();
	end
endmodule : tb_top
